/* File: fpuex_pkg.sv */
// Package for the floating point status and exception logic.
// Assumes one core clock and a synchronous active-low reset.
package fpuex_pkg;
	// ----------------------------------------------------------------
	// Status word layout
	// ----------------------------------------------------------------
	localparam int EXC_N         = 6;
	localparam int BIT_INVALID   = 0;
	localparam int BIT_DENORMAL  = 1;
	localparam int BIT_ZERODIV   = 2;
	localparam int BIT_OVERFLOW  = 3;
	localparam int BIT_UNDERFLOW = 4;
	localparam int BIT_INEXACT   = 5;
	localparam int BIT_SF        = 6;
	localparam int BIT_ES        = 7;
	localparam int BIT_C0        = 8;
	localparam int BIT_C1        = 9;
	localparam int BIT_C2        = 10;
	localparam int BIT_C3        = 14;
	localparam int BIT_BUSY      = 15;
	localparam logic [15:0] SW_RESET = 16'h0000;
	localparam logic [5:0]  MASK_RESET = 6'h3f;
	// ----------------------------------------------------------------
	// Pointer image layouts
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPUEX_PROT32,
		FPUEX_PROT16,
		FPUEX_REAL32,
		FPUEX_REAL16
	} fpuex_layout_type;
	localparam logic [7:0] OFS_CW   = 8'h00;
	localparam logic [7:0] OFS_SW   = 8'h04;
	localparam logic [7:0] OFS_TW   = 8'h08;
	localparam logic [7:0] OFS_IPLO = 8'h0c;
	localparam logic [7:0] OFS_IPHI = 8'h10;
	localparam logic [7:0] OFS_OPLO = 8'h14;
	localparam logic [7:0] OFS_OPHI = 8'h18;
	localparam int OPC_W = 11;
	// ----------------------------------------------------------------
	// Compare and class codes, C3 C2 C0 and C3 C2 C0 with C1 sign
	// ----------------------------------------------------------------
	localparam logic [2:0] CMP_GT  = 3'h0;
	localparam logic [2:0] CMP_LT  = 3'h1;
	localparam logic [2:0] CMP_EQ  = 3'h4;
	localparam logic [2:0] CMP_UNO = 3'h7;
	typedef enum logic [2:0] {
		FPUEX_CLS_UNSUP,
		FPUEX_CLS_NAN,
		FPUEX_CLS_NORMAL,
		FPUEX_CLS_INF,
		FPUEX_CLS_ZERO,
		FPUEX_CLS_EMPTY,
		FPUEX_CLS_DENORM
	} fpuex_class_type;
	localparam logic [2:0] CLS_UNSUP  = 3'h0;
	localparam logic [2:0] CLS_NAN    = 3'h1;
	localparam logic [2:0] CLS_NORMAL = 3'h2;
	localparam logic [2:0] CLS_INF    = 3'h3;
	localparam logic [2:0] CLS_ZERO   = 3'h4;
	localparam logic [2:0] CLS_EMPTY  = 3'h5;
	localparam logic [2:0] CLS_DENORM = 3'h6;
	// ----------------------------------------------------------------
	// Masked default result selections
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FPUEX_RES_NORMAL,
		FPUEX_RES_INDEF,
		FPUEX_RES_INF,
		FPUEX_RES_MAXFIN,
		FPUEX_RES_DENORM
	} fpuex_result_type;
endpackage

/* File: fpuex_status.sv */
// Floating point status word, exception flags, error output and pointers.
// Assumes the datapath reports exceptions and instruction decode as
// one-cycle strobes from logic on core_clk.
//
// Functional notes
// - Summary bit set when any unmasked flag is set, clear otherwise.
// - Error output low while the summary bit is set.
// - Stack invalid sets stack fault; bit 9 one for overflow, zero underflow.
// - Detected exceptions set their matching sticky flag.
// - Each flag has its own control word mask; masked takes default action.
// - Fixed precedence invalid, denormal, zero divide, overflow, underflow, inexact.
// - Pending unmasked fault traps vector 16, or external path if native enable.
// - Reload recomputes summary and mirror bit from flags and masks.
// - Reload leaving summary set drives the error output immediately.
// - On exception the faulting instruction and operand addresses are kept.
// - Each decode with no unmasked fault pending captures instruction address, opcode, and operand address if it has a memory operand.
// - Operand pointer may be stale when instruction had no memory operand.
// - Pointer image layout picked by mode and operand size; V86 uses real.
// - Compare sets C3 C2 C0 to 000, 001, 100 or 111.
// - Masked invalid yields indefinite result.
// - Zero divide with finite nonzero dividend; masked result is infinity.
// - Masked overflow yields largest finite or infinity; the code always selects FPUEX_RES_MAXFIN.
// - Masked underflow yields denormal or zero.
// - Denormal operand flagged; masked processing continues.
// - Inexact flagged on rounding; masked processing continues.
`timescale 1ns/100ps
module fpuex_status #(
	parameter int ADDR_W = 32
) (
	// Clock, reset, enable
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	input  wire logic                          clk_en,
	// Control word and core state
	input  wire logic [5:0]                    exc_mask,
	input  wire logic                          native_error_enable,
	input  wire logic                          prot_mode,
	input  wire logic                          v86_mode,
	input  wire logic                          opsize32,
	// Instruction decode
	input  wire logic                          decode_stb,
	input  wire logic [ADDR_W-1:0]             decode_ip,
	input  wire logic                          decode_has_mem,
	input  wire logic [ADDR_W-1:0]             decode_op_addr,
	input  wire logic [fpuex_pkg::OPC_W-1:0]   decode_opcode,
	input  wire logic                          fp_or_wait_issue,
	// Datapath exception detection
	input  wire logic                          exc_stb,
	input  wire logic                          det_invalid,
	input  wire logic                          det_stack,
	input  wire logic                          det_stack_over,
	input  wire logic                          det_denormal,
	input  wire logic                          det_zerodiv,
	input  wire logic                          det_overflow,
	input  wire logic                          det_underflow,
	input  wire logic                          det_inexact,
	// Condition code results
	input  wire logic                          cmp_stb,
	input  wire logic                          cmp_gt,
	input  wire logic                          cmp_lt,
	input  wire logic                          cmp_eq,
	input  wire logic                          exam_stb,
	input  wire fpuex_pkg::fpuex_class_type    exam_class,
	input  wire logic                          exam_sign,
	// Status reload and clear
	input  wire logic                          sw_load_stb,
	input  wire logic [15:0]                   sw_load_val,
	input  wire logic                          sw_clear_stb,
	// Outputs
	output logic [15:0]                        fpu_status_word,
	output logic                               fp_error_output_b,
	output logic                               fault_vector16,
	output logic                               fault_external,
	output fpuex_pkg::fpuex_result_type        masked_result,
	output logic [ADDR_W-1:0]                  fault_ip,
	output logic [ADDR_W-1:0]                  fault_op_addr,
	output logic [fpuex_pkg::OPC_W-1:0]        fault_opcode,
	output fpuex_pkg::fpuex_layout_type        image_layout
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [5:0]                  flags_ff, nxt_flags;
	logic                        sf_ff, nxt_sf;
	logic [3:0]                  cc_ff, nxt_cc;
	logic [ADDR_W-1:0]           ip_ff, op_ff;
	logic [fpuex_pkg::OPC_W-1:0] opc_ff;
	logic                        trap_ff;

	wire [5:0] det_vec = {det_inexact, det_underflow, det_overflow,
	                      det_zerodiv, det_denormal, det_invalid};
	// Zero divide is dropped when invalid already wins, per precedence.
	wire [5:0] det_eff;
	assign det_eff[fpuex_pkg::BIT_INVALID]   = det_invalid;
	assign det_eff[fpuex_pkg::BIT_DENORMAL]  = det_denormal & ~det_invalid;
	assign det_eff[fpuex_pkg::BIT_ZERODIV]   = det_zerodiv & ~det_invalid & ~det_denormal;
	assign det_eff[fpuex_pkg::BIT_OVERFLOW]  = det_overflow & ~det_invalid & ~det_zerodiv;
	assign det_eff[fpuex_pkg::BIT_UNDERFLOW] = det_underflow & ~det_invalid & ~det_overflow;
	assign det_eff[fpuex_pkg::BIT_INEXACT]   = det_inexact;

	// ----------------------------------------------------------------
	// Flag and condition code update
	// ----------------------------------------------------------------
	// A reload replaces the flags; a same-cycle detection still ORs in.
	wire [5:0] base_flags = sw_clear_stb ? 6'h00 :
	                        sw_load_stb  ? sw_load_val[5:0] : flags_ff;
	wire       base_sf    = sw_clear_stb ? 1'b0 :
	                        sw_load_stb  ? sw_load_val[fpuex_pkg::BIT_SF] : sf_ff;
	wire [3:0] load_cc    = {sw_load_val[fpuex_pkg::BIT_C3], sw_load_val[fpuex_pkg::BIT_C2],
	                         sw_load_val[fpuex_pkg::BIT_C1], sw_load_val[fpuex_pkg::BIT_C0]};
	wire       stack_exc  = exc_stb & det_invalid & det_stack;
	wire [2:0] cmp_code   = cmp_gt ? fpuex_pkg::CMP_GT :
	                        cmp_lt ? fpuex_pkg::CMP_LT :
	                        cmp_eq ? fpuex_pkg::CMP_EQ : fpuex_pkg::CMP_UNO;
	wire [2:0] cls_code   = 3'(exam_class);
	wire [3:0] cls_cc;
	// Class code bits map to C3 C2 C0 in the order zero/empty/denormal high.
	assign cls_cc = (cls_code == fpuex_pkg::CLS_UNSUP)  ? {2'b00, exam_sign, 1'b0} :
	                (cls_code == fpuex_pkg::CLS_NAN)    ? {2'b00, exam_sign, 1'b1} :
	                (cls_code == fpuex_pkg::CLS_NORMAL) ? {2'b01, exam_sign, 1'b0} :
	                (cls_code == fpuex_pkg::CLS_INF)    ? {2'b01, exam_sign, 1'b1} :
	                (cls_code == fpuex_pkg::CLS_ZERO)   ? {2'b10, exam_sign, 1'b0} :
	                (cls_code == fpuex_pkg::CLS_EMPTY)  ? {2'b10, exam_sign, 1'b1} :
	                                                      {2'b11, exam_sign, 1'b0};

	assign nxt_flags = base_flags | (exc_stb ? det_eff : 6'h00);
	assign nxt_sf    = base_sf | stack_exc;
	assign nxt_cc    = stack_exc    ? {cc_ff[3:2], det_stack_over, cc_ff[0]} :
	                   cmp_stb      ? {cmp_code[2], cmp_code[1], cc_ff[1], cmp_code[0]} :
	                   exam_stb     ? cls_cc :
	                   sw_clear_stb ? 4'h0 :
	                   sw_load_stb  ? load_cc : cc_ff;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			flags_ff <= fpuex_pkg::SW_RESET[5:0];
			sf_ff    <= 1'b0;
			cc_ff    <= 4'h0;
		end
		else if (clk_en)
		begin
			flags_ff <= nxt_flags;
			sf_ff    <= nxt_sf;
			cc_ff    <= nxt_cc;
		end
	end

	// ----------------------------------------------------------------
	// Summary, error output and trap
	// ----------------------------------------------------------------
	// Summary is always derived, so a reload never copies bits 7 and 15.
	wire es = |(flags_ff & ~exc_mask);
	assign fpu_status_word = {es, cc_ff[3], 3'h0, cc_ff[2], cc_ff[1], cc_ff[0],
	                          es, sf_ff, flags_ff};
	// Driven straight from state, so a reload shows on the next cycle.
	assign fp_error_output_b = ~es;

	wire raise = fp_or_wait_issue & es & clk_en;
	assign fault_vector16 = raise & ~native_error_enable;
	assign fault_external = raise & native_error_enable;

	// Default action for the highest-precedence masked exception.
	wire [5:0] mhit = det_eff & exc_mask;
	assign masked_result = ~exc_stb                                   ? fpuex_pkg::FPUEX_RES_NORMAL :
	                       mhit[fpuex_pkg::BIT_INVALID]   ? fpuex_pkg::FPUEX_RES_INDEF :
	                       mhit[fpuex_pkg::BIT_ZERODIV]   ? fpuex_pkg::FPUEX_RES_INF :
	                       mhit[fpuex_pkg::BIT_OVERFLOW]  ? fpuex_pkg::FPUEX_RES_MAXFIN :
	                       mhit[fpuex_pkg::BIT_UNDERFLOW] ? fpuex_pkg::FPUEX_RES_DENORM :
	                                                        fpuex_pkg::FPUEX_RES_NORMAL;

	// ----------------------------------------------------------------
	// Instruction and operand pointers
	// ----------------------------------------------------------------
	// Capture at decode; once an unmasked fault is latched, later decodes
	// are held off so the handler sees the faulting instruction.
	wire new_fault = exc_stb & |(det_eff & ~exc_mask);
	wire cap_en    = decode_stb & ~trap_ff & ~es;
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ip_ff   <= '0;
			op_ff   <= '0;
			opc_ff  <= '0;
			trap_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (cap_en)
				ip_ff <= decode_ip;
			if (cap_en && decode_has_mem)
				op_ff <= decode_op_addr;
			if (cap_en)
				opc_ff <= decode_opcode;
			trap_ff <= (trap_ff | new_fault) & ~sw_clear_stb;
		end
	end
	assign fault_ip      = ip_ff;
	assign fault_op_addr = op_ff;
	assign fault_opcode  = opc_ff;

	// Virtual-86 code stores with the real-mode images.
	wire is_prot = prot_mode & ~v86_mode;
	assign image_layout = is_prot ? (opsize32 ? fpuex_pkg::FPUEX_PROT32 : fpuex_pkg::FPUEX_PROT16) :
	                                (opsize32 ? fpuex_pkg::FPUEX_REAL32 : fpuex_pkg::FPUEX_REAL16);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_es_def;
		@(posedge core_clk) disable iff (!rst_b)
		fpu_status_word[fpuex_pkg::BIT_ES] == |(fpu_status_word[5:0] & ~exc_mask);
	endproperty
	a_es_def: assert property (p_es_def) else $error("summary bit mismatch");

	property p_fp_error_output;
		@(posedge core_clk) disable iff (!rst_b)
		fp_error_output_b == ~fpu_status_word[fpuex_pkg::BIT_ES];
	endproperty
	a_fp_error_output: assert property (p_fp_error_output) else $error("error output wrong");

	property p_sf;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && stack_exc |=> fpu_status_word[fpuex_pkg::BIT_SF] &&
		                        fpu_status_word[fpuex_pkg::BIT_C1] == $past(det_stack_over);
	endproperty
	a_sf: assert property (p_sf) else $error("stack fault not recorded");

	property p_flag_set;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && exc_stb && det_invalid |=> fpu_status_word[fpuex_pkg::BIT_INVALID];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("invalid flag lost");

	property p_prec;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && exc_stb && det_invalid && !sw_clear_stb && !sw_load_stb && !flags_ff[2]
		|=> !fpu_status_word[fpuex_pkg::BIT_ZERODIV];
	endproperty
	a_prec: assert property (p_prec) else $error("precedence violated");

	property p_trap;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && fp_or_wait_issue && !fp_error_output_b |-> (fault_vector16 ^ fault_external) &&
		                                                 fault_external == native_error_enable;
	endproperty
	a_trap: assert property (p_trap) else $error("fault routing wrong");

	property p_mirror;
		@(posedge core_clk) disable iff (!rst_b)
		fpu_status_word[fpuex_pkg::BIT_BUSY] == fpu_status_word[fpuex_pkg::BIT_ES];
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bit mismatch");

	property p_reload;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && sw_load_stb && !sw_clear_stb && |(sw_load_val[5:0] & ~exc_mask) ##1 $stable(exc_mask)
		|-> !fp_error_output_b;
	endproperty
	a_reload: assert property (p_reload) else $error("reload did not raise error");

	property p_cmp;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && cmp_stb && cmp_eq && !cmp_gt && !cmp_lt && !stack_exc
		|=> {fpu_status_word[fpuex_pkg::BIT_C3], fpu_status_word[fpuex_pkg::BIT_C2],
		     fpu_status_word[fpuex_pkg::BIT_C0]} == fpuex_pkg::CMP_EQ;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare code wrong");

	property p_cap;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en && cap_en |=> fault_ip == $past(decode_ip) && fault_opcode == $past(decode_opcode);
	endproperty
	a_cap: assert property (p_cap) else $error("pointer capture failed");
endmodule

/* File: fpuex_core_model.sv */
// Core-side model: issues floating point or wait instructions and records traps.
// Assumes the bench asks for one issue at a time and waits on issue_busy.
`timescale 1ns/100ps
module fpuex_core_model (
	// Clock and bench request
	input  wire logic       core_clk,
	input  wire logic       issue_go,
	input  wire logic [3:0] issue_delay,
	// Block side
	input  wire logic       fault_vector16,
	input  wire logic       fault_external,
	output logic            fp_or_wait_issue,
	output logic            issue_busy,
	output logic [1:0]      trap_kind_ff
);
	initial
	begin
		fp_or_wait_issue = 1'b0;
		issue_busy = 1'b0;
		trap_kind_ff = 2'h0;
	end
	// A slow core lets some cycles pass before the next instruction arrives.
	// Traps are sampled mid-cycle since they are combinational pulses.
	always
	begin
		@(posedge core_clk iff issue_go);
		#1 issue_busy = 1'b1;
		repeat (issue_delay) @(posedge core_clk);
		#1 fp_or_wait_issue = 1'b1;
		@(negedge core_clk);
		trap_kind_ff = {fault_external, fault_vector16};
		@(posedge core_clk);
		#1 fp_or_wait_issue = 1'b0;
		issue_busy = 1'b0;
	end
endmodule

/* File: test_fpuex_status.sv */
// Self-checking bench for the status and exception logic.
// Assumes the core model file is compiled first.
`timescale 1ns/100ps
module test_fpuex_status;
	typedef struct {int sel; logic [31:0] v;} fpuex_note_type;
	fpuex_note_type notes[$];
	int num_errors = 0;
	int n_checks = 0;
	logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, native_error_enable = 1'b0;
	logic [5:0] exc_mask = 6'h3f;
	logic prot_mode = 1'b0, v86_mode = 1'b0, opsize32 = 1'b0, issue_go = 1'b0;
	logic decode_stb = 1'b0, decode_has_mem = 1'b0, fp_or_wait_issue, issue_busy;
	logic [31:0] decode_ip = 32'h0, decode_op_addr = 32'h0, ip_v, op_v, got;
	logic [10:0] decode_opcode = 11'h0;
	logic exc_stb = 1'b0, det_invalid = 1'b0, det_stack = 1'b0, det_stack_over = 1'b0;
	logic det_denormal = 1'b0, det_zerodiv = 1'b0, det_overflow = 1'b0;
	logic det_underflow = 1'b0, det_inexact = 1'b0;
	logic cmp_stb = 1'b0, cmp_gt = 1'b0, cmp_lt = 1'b0, cmp_eq = 1'b0;
	logic exam_stb = 1'b0, exam_sign = 1'b0, sw_load_stb = 1'b0, sw_clear_stb = 1'b0;
	fpuex_pkg::fpuex_class_type exam_class = fpuex_pkg::FPUEX_CLS_UNSUP;
	logic [15:0] sw_load_val = 16'h0, fpu_status_word;
	logic fp_error_output_b, fault_vector16, fault_external;
	logic [3:0] issue_delay = 4'h0;
	logic [1:0] trap_kind_ff;
	logic [31:0] fault_ip, fault_op_addr;
	logic [10:0] fault_opcode;
	fpuex_pkg::fpuex_result_type masked_result;
	fpuex_pkg::fpuex_layout_type image_layout;
	localparam logic [3:0] CLS_CC[7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc};
	localparam logic [2:0] RES_CODE[6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h0};
	localparam logic [2:0] CMP_CODE[4] = '{fpuex_pkg::CMP_GT, fpuex_pkg::CMP_LT,
		fpuex_pkg::CMP_EQ, fpuex_pkg::CMP_UNO};

	fpuex_status u_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .exc_mask(exc_mask),
		.native_error_enable(native_error_enable), .prot_mode(prot_mode), .v86_mode(v86_mode),
		.opsize32(opsize32), .decode_stb(decode_stb), .decode_ip(decode_ip),
		.decode_has_mem(decode_has_mem), .decode_op_addr(decode_op_addr), .decode_opcode(decode_opcode),
		.fp_or_wait_issue(fp_or_wait_issue), .exc_stb(exc_stb), .det_invalid(det_invalid),
		.det_stack(det_stack), .det_stack_over(det_stack_over), .det_denormal(det_denormal),
		.det_zerodiv(det_zerodiv), .det_overflow(det_overflow), .det_underflow(det_underflow),
		.det_inexact(det_inexact), .cmp_stb(cmp_stb), .cmp_gt(cmp_gt), .cmp_lt(cmp_lt),
		.cmp_eq(cmp_eq), .exam_stb(exam_stb), .exam_class(exam_class), .exam_sign(exam_sign),
		.sw_load_stb(sw_load_stb), .sw_load_val(sw_load_val), .sw_clear_stb(sw_clear_stb),
		.fpu_status_word(fpu_status_word), .fp_error_output_b(fp_error_output_b),
		.fault_vector16(fault_vector16), .fault_external(fault_external),
		.masked_result(masked_result), .fault_ip(fault_ip), .fault_op_addr(fault_op_addr),
		.fault_opcode(fault_opcode), .image_layout(image_layout));
	fpuex_core_model u_core (.core_clk(core_clk), .issue_go(issue_go), .issue_delay(issue_delay),
		.fault_vector16(fault_vector16), .fault_external(fault_external),
		.fp_or_wait_issue(fp_or_wait_issue), .issue_busy(issue_busy), .trap_kind_ff(trap_kind_ff));

	initial
	begin
		forever #25 core_clk = ~core_clk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] exp_sw(logic [5:0] f, logic sf, logic [3:0] cc, logic [5:0] m);
		logic es;
		es = |(f & ~m);
		return {es, cc[3], 3'h0, cc[2], cc[1], cc[0], es, sf, f};
	endfunction
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic note(int sel, logic [31:0] v);
		notes.push_back('{sel, v});
	endtask
	task automatic exc(logic [5:0] d, logic stk, logic over);
		{det_inexact, det_underflow, det_overflow, det_zerodiv, det_denormal, det_invalid} = d;
		{det_stack, det_stack_over} = {stk, over};
		exc_stb = 1'b1;
		step;
		exc_stb = 1'b0;
	endtask
	task automatic clear_all;
		sw_clear_stb = 1'b1;
		step;
		sw_clear_stb = 1'b0;
	endtask
	task automatic issue(logic ne, logic [3:0] dly);
		int k;
		{native_error_enable, issue_delay, issue_go} = {ne, dly, 1'b1};
		step;
		issue_go = 1'b0;
		k = 0;
		@(negedge core_clk);
		while (issue_busy && k < 20)
		begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 20)
		begin
			num_errors++;
			final_report;
		end
		step;
	endtask
	task automatic decode(logic mem);
		{decode_ip, decode_op_addr, decode_opcode} = {$urandom, $urandom, 11'($urandom)};
		{decode_has_mem, decode_stb} = {mem, 1'b1};
		step;
		decode_stb = 1'b0;
	endtask
	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(negedge core_clk)
	begin
		while (notes.size() > 0)
		begin
			fpuex_note_type n;
			n = notes.pop_front();
			case (n.sel)
				0: got = {16'h0, fpu_status_word};
				1: got = {31'h0, fp_error_output_b};
				2: got = fault_ip;
				3: got = fault_op_addr;
				4: got = {21'h0, fault_opcode};
				5: got = {30'h0, image_layout};
				7: got = {29'h0, masked_result};
				default: got = {30'h0, trap_kind_ff};
			endcase
			n_checks++;
			if (got !== n.v)
			begin
				num_errors++;
				$display("CHECK FAILED t=%0t exp=%h got=%h", $time, n.v, got);
			end
		end
	end
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		int b;
		logic [5:0] m;
		void'($urandom(32'hff3e57bd));
		repeat (5) step;
		rst_b = 1'b1;
		note(1, 32'h1);
		for (int i = 0; i < 12; i++)
		begin
			b = i % 6;
			m = (i < 6) ? 6'h3f : ~(6'h01 << b);
			exc_mask = m;
			note(7, (i < 6) ? {29'h0, RES_CODE[b]} : 32'h0);
			exc(6'h01 << b, 1'b0, 1'b0);
			note(0, {16'h0, exp_sw(6'h01 << b, 1'b0, 4'h0, m)});
			note(1, {31'h0, i < 6});
			issue(b[0], 4'($urandom % 4));
			note(6, (i < 6) ? 32'h0 : (b[0] ? 32'h2 : 32'h1));
			clear_all;
		end
		exc_mask = 6'h3f;
		exc(6'h01, 1'b1, 1'b1);
		note(0, {16'h0, exp_sw(6'h01, 1'b1, 4'h2, 6'h3f)});
		exc(6'h01, 1'b1, 1'b0);
		note(0, {16'h0, exp_sw(6'h01, 1'b1, 4'h0, 6'h3f)});
		clear_all;
		exc(6'h3f, 1'b0, 1'b0);
		note(0, {16'h0, exp_sw(6'h21, 1'b0, 4'h0, 6'h3f)});
		clear_all;
		clk_en = 1'b0;
		exc(6'h3f, 1'b0, 1'b0);
		note(0, 32'h0);
		clk_en = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			{cmp_gt, cmp_lt, cmp_eq, cmp_stb} = {3'h4 >> k, 1'b1};
			step;
			cmp_stb = 1'b0;
			note(0, {16'h0, exp_sw(6'h0, 1'b0, {CMP_CODE[k][2:1], 1'b0, CMP_CODE[k][0]}, 6'h3f)});
		end
		for (int k = 0; k < 14; k++)
		begin
			exam_class = fpuex_pkg::fpuex_class_type'(k / 2);
			{exam_sign, exam_stb} = {k[0], 1'b1};
			step;
			exam_stb = 1'b0;
			note(0, {16'h0, exp_sw(6'h0, 1'b0, CLS_CC[k / 2] | {2'h0, k[0], 1'b0}, 6'h3f)});
		end
		clear_all;
		{exc_mask, sw_load_val, sw_load_stb} = {6'h3e, 16'h0001, 1'b1};
		step;
		note(0, 32'h8081);
		note(1, 32'h0);
		sw_load_val = 16'h8080;
		step;
		sw_load_stb = 1'b0;
		note(0, 32'h0);
		note(1, 32'h1);
		decode(1'b1);
		{ip_v, op_v} = {decode_ip, decode_op_addr};
		note(2, ip_v);
		note(3, op_v);
		note(4, {21'h0, decode_opcode});
		decode(1'b0);
		ip_v = decode_ip;
		note(2, ip_v);
		note(3, op_v);
		exc(6'h01, 1'b0, 1'b0);
		decode(1'b1);
		note(2, ip_v);
		note(3, op_v);
		clear_all;
		for (int k = 0; k < 8; k++)
		begin
			{prot_mode, v86_mode, opsize32} = 3'(k);
			note(5, (k[2] && !k[1]) ? {31'h0, !k[0]} : {30'h0, 1'b1, !k[0]});
			step;
		end
		step;
		final_report;
	end
endmodule
